//--- core/bmo_pkg.sv
package bmo_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [3:0]  REG_WAIT_CTRL   = 4'h0;
	localparam logic [3:0]  REG_PROG_WAIT   = 4'h4;
	localparam logic [3:0]  REG_OVERLAY     = 4'h8;
	localparam logic [3:0]  REG_STATUS      = 4'hC;
	// wait control fields: four io regions, data wait, mode bit
	localparam int          IO_WAIT_LSB     = 0;
	localparam int          DATA_WAIT_LSB   = 12;
	localparam int          WAIT_MODE_BIT   = 15;
	localparam int          PM_OVL_LSB      = 0;
	localparam int          DM_OVL_LSB      = 4;
	localparam logic [15:0] WAIT_CTRL_RST   = 16'h0000;
	localparam logic [2:0]  PROG_WAIT_RST   = 3'h0;
	localparam logic [3:0]  OVL_RST         = 4'h0;
	// boot and memory map figures
	localparam int          BOOT_WORDS      = 32;
	localparam logic [13:0] WINDOW_BASE     = 14'h2000;
	localparam logic [13:0] CTRL_REG_BASE   = 14'h3FE0;
	localparam logic [10:0] IO_REGION_SIZE  = 11'h200;
	localparam logic [3:0]  OVL_EXT_ONE     = 4'h1;
	localparam logic [3:0]  OVL_EXT_TWO     = 4'h2;
	// strap codes as {c,b,a}
	localparam logic [2:0]  STRAP_BYTE_FULL = 3'h0;
	localparam logic [2:0]  STRAP_NOBOOT    = 3'h2;
	localparam logic [2:0]  STRAP_BYTE_HOST = 3'h4;
	localparam logic [2:0]  STRAP_HOST_DMA  = 3'h5;

	typedef enum logic [1:0] {
		BMO_SPACE_PM = 2'b00,
		BMO_SPACE_DM = 2'b01,
		BMO_SPACE_IO = 2'b10
	} bmo_space_t;

	typedef enum logic [1:0] {
		BMO_BOOT_NONE = 2'b00,
		BMO_BOOT_BYTE = 2'b01,
		BMO_BOOT_HOST = 2'b10
	} bmo_boot_t;

	typedef struct packed {
		bmo_space_t  space;
		logic        fetch;
		logic        we;
		logic [13:0] addr;
		logic [23:0] wdata;
	} bmo_acc_req_t;

	typedef struct packed {
		logic        mode_a;
		logic        mode_b;
		logic        mode_c;
		logic        mode_d;
	} bmo_strap_t;
endpackage

//--- core/bmo_ctrl.sv
`timescale 1ns/1ps
// Function
// - capture flag-pin mode strap during reset
// - strap 000: full mode, byte boot 32
// - strap 010: full mode, no boot
// - strap 100: host mode, byte boot 32
// - strap 101: host mode, wait program word 0
// - host, D low: acknowledge actively driven
// - host, D high: acknowledge open drain
// - program space 8K internal, two overlays
// - overlay 2 sets bit 13, overlay 1 clears it, low 13 bits
// - host mode: one address line, no fetch
// - data space 8K, 32 control registers, one cycle
// - data external accesses use data wait
// - wait N, or 2N+1 in mode one
// - io space 2048, eleven address bits
// - four io regions, own wait each
module bmo_ctrl
	import bmo_pkg::*;
(
	input  wire logic         core_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [31:0]  wb_adr_i,
	input  wire logic [31:0]  wb_dat_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic         wb_we_i,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	output logic      [31:0]  wb_dat_o,
	output logic              wb_ack_o,
	input  wire logic         mode_a_i,
	input  wire logic         mode_b_i,
	input  wire logic         mode_d_i,
	input  wire logic         shared_flag_pin_two_i,
	input  wire logic         byte_memory_dma_word_i,
	input  wire logic         host_internal_dma_pm0_wr_i,
	input  wire logic         host_busy_i,
	output logic              host_access_ack_n_o,
	output logic              host_access_ack_n_oe_o,
	output logic              full_mem_mode_o,
	output logic              byte_boot_req_o,
	output logic              hold_exec_o,
	input  wire logic         acc_valid_i,
	input  wire bmo_acc_req_t acc_req_i,
	input  wire logic [23:0]  ext_data_i,
	output logic              acc_done_o,
	output logic              acc_err_o,
	output logic      [23:0]  acc_rdata_o,
	output logic      [13:0]  ext_addr_o,
	output logic      [23:0]  ext_data_o,
	output logic              ext_data_oe_o,
	output logic              pm_sel_n_o,
	output logic              dm_sel_n_o,
	output logic              io_sel_n_o,
	output logic              rd_n_o,
	output logic              wr_n_o
);

	// wait states: N in normal mode, 2N+1 otherwise
	function automatic logic [3:0] wait_count(input logic [2:0] n, input logic mode);
		wait_count = mode ? {n, 1'b1} : {1'b0, n};
	endfunction

	// ---------------- strap capture ----------------
	// sync chain is not reset so it samples the straps while reset is held
	bmo_strap_t strap_s1;
	bmo_strap_t strap_s2;
	bmo_strap_t strap;
	logic       captured;
	bmo_strap_t next_strap;
	logic       next_captured;

	always_ff @(posedge core_clk_i) begin
		strap_s1 <= '{mode_a: mode_a_i, mode_b: mode_b_i,
			mode_c: shared_flag_pin_two_i, mode_d: mode_d_i};
		strap_s2 <= strap_s1;
	end

	always_comb begin
		next_strap    = strap;
		next_captured = 1'b1;
		// pin value taken before the driver lets go
		if (!captured) begin
			next_strap = strap_s2;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strap    <= '0;
			captured <= 1'b0;
		end else begin
			strap    <= next_strap;
			captured <= next_captured;
		end
	end

	// ---------------- boot control ----------------
	logic [2:0] strap_code;
	bmo_boot_t  boot_kind;
	logic       host_mode;
	logic [5:0] boot_cnt;
	logic [5:0] next_boot_cnt;
	logic       next_hold;
	logic       next_byte_req;
	logic       next_full;

	assign strap_code = {strap.mode_c, strap.mode_b, strap.mode_a};
	assign host_mode  = strap.mode_c;

	always_comb begin
		case (strap_code)
			STRAP_BYTE_FULL: boot_kind = BMO_BOOT_BYTE;
			STRAP_NOBOOT:    boot_kind = BMO_BOOT_NONE;
			STRAP_BYTE_HOST: boot_kind = BMO_BOOT_BYTE;
			STRAP_HOST_DMA:  boot_kind = BMO_BOOT_HOST;
			default:         boot_kind = BMO_BOOT_NONE;
		endcase
	end

	always_comb begin
		next_boot_cnt = boot_cnt;
		next_hold     = hold_exec_o;
		next_byte_req = byte_boot_req_o;
		// mode output waits for the latched strap, no false full-mode pulse
		next_full     = captured ? ~host_mode : full_mem_mode_o;
		if (!captured) begin
			next_boot_cnt = '0;
			next_hold     = 1'b1;
			next_byte_req = 1'b0;
		end else if (hold_exec_o) begin
			case (boot_kind)
				BMO_BOOT_BYTE: begin
					// hold until all boot words are in
					next_byte_req = 1'b1;
					if (byte_memory_dma_word_i) begin
						next_boot_cnt = boot_cnt + 6'd1;
					end
					if (boot_cnt == 6'(BOOT_WORDS)) begin
						next_hold     = 1'b0;
						next_byte_req = 1'b0;
					end
				end
				BMO_BOOT_HOST: begin
					// release on host write of program word 0
					if (host_internal_dma_pm0_wr_i) begin
						next_hold = 1'b0;
					end
				end
				default: next_hold = 1'b0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			boot_cnt        <= '0;
			hold_exec_o     <= 1'b1;
			byte_boot_req_o <= 1'b0;
			full_mem_mode_o <= 1'b0;
		end else begin
			boot_cnt        <= next_boot_cnt;
			hold_exec_o     <= next_hold;
			byte_boot_req_o <= next_byte_req;
			full_mem_mode_o <= next_full;
		end
	end

	// ---------------- host acknowledge pin ----------------
	logic next_ack_n;
	logic next_ack_oe;

	always_comb begin
		next_ack_n  = host_busy_i;
		next_ack_oe = 1'b0;
		if (captured && host_mode) begin
			if (!strap.mode_d) begin
				next_ack_oe = 1'b1;
			end else begin
				// drive high only, external pull-down gives low
				next_ack_n  = 1'b1;
				next_ack_oe = host_busy_i;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			host_access_ack_n_o    <= 1'b1;
			host_access_ack_n_oe_o <= 1'b0;
		end else begin
			host_access_ack_n_o    <= next_ack_n;
			host_access_ack_n_oe_o <= next_ack_oe;
		end
	end

	// ---------------- wishbone registers ----------------
	logic [15:0] wait_ctrl;
	logic [2:0]  program_wait_count;
	logic [3:0]  program_overlay_select;
	logic [3:0]  data_overlay_select;
	logic [15:0] next_wait_ctrl;
	logic [2:0]  next_program_wait_count;
	logic [3:0]  next_pm_ovl;
	logic [3:0]  next_dm_ovl;
	logic [31:0] next_wb_dat;
	logic        next_wb_ack;
	logic        wb_hit;
	logic [3:0]  wb_off;

	assign wb_off = wb_adr_i[3:0];
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_comb begin
		next_wait_ctrl = wait_ctrl;
		next_program_wait_count     = program_wait_count;
		next_pm_ovl    = program_overlay_select;
		next_dm_ovl    = data_overlay_select;
		next_wb_dat    = '0;
		next_wb_ack    = wb_hit;
		if (wb_hit && wb_adr_i[31:4] == '0) begin
			case (wb_off)
				REG_WAIT_CTRL: begin
					next_wb_dat = {16'h0000, wait_ctrl};
					if (wb_we_i && wb_sel_i[0]) next_wait_ctrl[7:0] = wb_dat_i[7:0];
					if (wb_we_i && wb_sel_i[1]) next_wait_ctrl[15:8] = wb_dat_i[15:8];
				end
				REG_PROG_WAIT: begin
					next_wb_dat = {29'h0, program_wait_count};
					if (wb_we_i && wb_sel_i[0]) next_program_wait_count = wb_dat_i[2:0];
				end
				REG_OVERLAY: begin
					next_wb_dat = {24'h0, data_overlay_select, program_overlay_select};
					if (wb_we_i && wb_sel_i[0]) begin
						next_pm_ovl = wb_dat_i[PM_OVL_LSB +: 4];
						next_dm_ovl = wb_dat_i[DM_OVL_LSB +: 4];
					end
				end
				REG_STATUS: begin
					next_wb_dat = {24'h0, hold_exec_o, full_mem_mode_o, boot_kind,
						strap.mode_d, strap_code};
				end
				default: next_wb_dat = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_ctrl              <= WAIT_CTRL_RST;
			program_wait_count     <= PROG_WAIT_RST;
			program_overlay_select <= OVL_RST;
			data_overlay_select    <= OVL_RST;
			wb_dat_o               <= '0;
			wb_ack_o               <= 1'b0;
		end else begin
			wait_ctrl              <= next_wait_ctrl;
			program_wait_count     <= next_program_wait_count;
			program_overlay_select <= next_pm_ovl;
			data_overlay_select    <= next_dm_ovl;
			wb_dat_o               <= next_wb_dat;
			wb_ack_o               <= next_wb_ack;
		end
	end

	// ---------------- external access sequencer ----------------
	typedef enum logic [1:0] {
		BMO_ST_IDLE   = 2'b00,
		BMO_ST_STROBE = 2'b01
	} bmo_acc_st_t;

	bmo_acc_st_t  acc_st;
	bmo_acc_st_t  next_acc_st;
	bmo_acc_req_t acc_lat;
	bmo_acc_req_t next_acc_lat;
	logic [3:0]   wait_left;
	logic [3:0]   next_wait_left;
	logic [3:0]   ovl;
	logic         in_window;
	logic         is_ext;
	logic         bad;
	logic [13:0]  map_addr;
	logic [3:0]   acc_wait;
	logic [1:0]   io_region;
	logic         next_done;
	logic         next_err;
	logic [23:0]  next_rdata;
	logic [13:0]  next_ext_addr;
	logic         next_pm_sel_n;
	logic         next_dm_sel_n;
	logic         next_io_sel_n;
	logic         next_rd_n;
	logic         next_wr_n;
	logic         next_oe;
	logic [23:0]  next_wdata;

	// address decode of the incoming request
	always_comb begin
		ovl       = (acc_req_i.space == BMO_SPACE_PM) ? program_overlay_select
			: data_overlay_select;
		// lower 8K internal, upper window overlays
		in_window = acc_req_i.addr >= WINDOW_BASE;
		is_ext    = 1'b0;
		bad       = 1'b0;
		map_addr  = '0;
		io_region = acc_req_i.addr[10:9];
		acc_wait  = '0;
		case (acc_req_i.space)
			BMO_SPACE_PM, BMO_SPACE_DM: begin
				// control registers stay internal, one cycle
				if (in_window && !(acc_req_i.space == BMO_SPACE_DM
						&& acc_req_i.addr >= CTRL_REG_BASE)) begin
					if (ovl == OVL_EXT_ONE || ovl == OVL_EXT_TWO) begin
						is_ext   = 1'b1;
						map_addr = {ovl == OVL_EXT_TWO, acc_req_i.addr[12:0]};
					end else if (ovl != OVL_RST) begin
						bad = 1'b1;
					end
				end
				acc_wait = (acc_req_i.space == BMO_SPACE_DM)
					? wait_count(wait_ctrl[DATA_WAIT_LSB +: 3], wait_ctrl[WAIT_MODE_BIT])
					: wait_count(program_wait_count, wait_ctrl[WAIT_MODE_BIT]);
			end
			BMO_SPACE_IO: begin
				// eleven address bits, upper left low
				is_ext   = 1'b1;
				bad      = host_mode;
				map_addr = {3'h0, acc_req_i.addr[10:0]};
				// region picks its own wait field
				acc_wait = wait_count(wait_ctrl[IO_WAIT_LSB + 3 * io_region +: 3],
					wait_ctrl[WAIT_MODE_BIT]);
			end
			default: bad = 1'b1;
		endcase
		// host mode: single address line, no external fetch
		if (host_mode && is_ext) begin
			map_addr = {13'h0, map_addr[0]};
			if (acc_req_i.fetch) bad = 1'b1;
		end
	end

	always_comb begin
		next_acc_st    = acc_st;
		next_acc_lat   = acc_lat;
		next_wait_left = wait_left;
		next_done      = 1'b0;
		next_err       = 1'b0;
		next_rdata     = acc_rdata_o;
		next_ext_addr  = ext_addr_o;
		next_pm_sel_n  = pm_sel_n_o;
		next_dm_sel_n  = dm_sel_n_o;
		next_io_sel_n  = io_sel_n_o;
		next_rd_n      = rd_n_o;
		next_wr_n      = wr_n_o;
		next_oe        = ext_data_oe_o;
		next_wdata     = ext_data_o;
		case (acc_st)
			BMO_ST_IDLE: begin
				if (acc_valid_i && !acc_done_o) begin
					if (bad) begin
						next_done = 1'b1;
						next_err  = 1'b1;
					end else if (!is_ext) begin
						next_done = 1'b1;
					end else begin
						// assert select and strobe, load wait
						next_acc_st    = BMO_ST_STROBE;
						next_acc_lat   = acc_req_i;
						next_wait_left = acc_wait;
						next_ext_addr  = map_addr;
						next_pm_sel_n  = acc_req_i.space != BMO_SPACE_PM;
						next_dm_sel_n  = acc_req_i.space != BMO_SPACE_DM;
						next_io_sel_n  = acc_req_i.space != BMO_SPACE_IO;
						next_rd_n      = acc_req_i.we;
						next_wr_n      = !acc_req_i.we;
						next_oe        = acc_req_i.we;
						next_wdata     = acc_req_i.wdata;
					end
				end
			end
			BMO_ST_STROBE: begin
				// hold strobes for the wait count
				if (wait_left != 4'h0) begin
					next_wait_left = wait_left - 4'h1;
				end else begin
					next_acc_st   = BMO_ST_IDLE;
					next_done     = 1'b1;
					next_rdata    = acc_lat.we ? acc_rdata_o : ext_data_i;
					next_pm_sel_n = 1'b1;
					next_dm_sel_n = 1'b1;
					next_io_sel_n = 1'b1;
					next_rd_n     = 1'b1;
					next_wr_n     = 1'b1;
					next_oe       = 1'b0;
				end
			end
			default: next_acc_st = BMO_ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			acc_st        <= BMO_ST_IDLE;
			acc_lat       <= '0;
			wait_left     <= '0;
			acc_done_o    <= 1'b0;
			acc_err_o     <= 1'b0;
			acc_rdata_o   <= '0;
			ext_addr_o    <= '0;
			pm_sel_n_o    <= 1'b1;
			dm_sel_n_o    <= 1'b1;
			io_sel_n_o    <= 1'b1;
			rd_n_o        <= 1'b1;
			wr_n_o        <= 1'b1;
			ext_data_oe_o <= 1'b0;
			ext_data_o    <= '0;
		end else begin
			acc_st        <= next_acc_st;
			acc_lat       <= next_acc_lat;
			wait_left     <= next_wait_left;
			acc_done_o    <= next_done;
			acc_err_o     <= next_err;
			acc_rdata_o   <= next_rdata;
			ext_addr_o    <= next_ext_addr;
			pm_sel_n_o    <= next_pm_sel_n;
			dm_sel_n_o    <= next_dm_sel_n;
			io_sel_n_o    <= next_io_sel_n;
			rd_n_o        <= next_rd_n;
			wr_n_o        <= next_wr_n;
			ext_data_oe_o <= next_oe;
			ext_data_o    <= next_wdata;
		end
	end

endmodule // bmo_ctrl

//--- test/bmo_ctrl_properties.sv
`timescale 1ns/1ps
module bmo_ctrl_properties (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        mode_d_i,
	input  wire logic        byte_memory_dma_word_i,
	input  wire logic        host_internal_dma_pm0_wr_i,
	input  wire logic        host_access_ack_n_o,
	input  wire logic        host_access_ack_n_oe_o,
	input  wire logic        full_mem_mode_o,
	input  wire logic        hold_exec_o,
	input  wire logic        acc_done_o,
	input  wire logic        acc_err_o,
	input  wire logic [13:0] ext_addr_o,
	input  wire logic        pm_sel_n_o,
	input  wire logic        dm_sel_n_o,
	input  wire logic        io_sel_n_o
);
	logic [1:0] age;
	logic       settled;
	// strap-driven outputs are trusted only a few edges after release
	assign settled = (age == 2'h3);
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	done_pulse_a: assert property (acc_done_o |=> !acc_done_o)
		else $error("access done longer than one cycle");
	err_done_a: assert property (acc_err_o |-> acc_done_o)
		else $error("access error without done");
	sel_done_a: assert property ($rose(pm_sel_n_o) || $rose(dm_sel_n_o) || $rose(io_sel_n_o)
		|-> acc_done_o) else $error("select released without done");
	host_drive_a: assert property (settled && !full_mem_mode_o && !mode_d_i
		|-> host_access_ack_n_oe_o) else $error("acknowledge not driven");
	host_od_a: assert property (settled && !full_mem_mode_o && mode_d_i
		|-> host_access_ack_n_o) else $error("open drain acknowledge driven low");
	full_quiet_a: assert property (settled && full_mem_mode_o |-> !host_access_ack_n_oe_o)
		else $error("acknowledge driven in full mode");
	hold_drop_a: assert property (settled && $fell(hold_exec_o) |->
		$past(byte_memory_dma_word_i, 2) || $past(byte_memory_dma_word_i, 3) ||
		$past(host_internal_dma_pm0_wr_i) || $past(host_internal_dma_pm0_wr_i, 2))
		else $error("hold released without boot event");
	host_addr_a: assert property (settled && !full_mem_mode_o && !dm_sel_n_o
		|-> ext_addr_o[13:1] == 13'h0) else $error("host mode drives upper address");
	host_no_io_a: assert property (settled && !full_mem_mode_o |-> io_sel_n_o)
		else $error("io select in host mode");

	cover property ($fell(hold_exec_o));
	cover property (acc_err_o);
	cover property ($rose(io_sel_n_o));
endmodule // bmo_ctrl_properties

//--- test/bmo_ext_mem.sv
`timescale 1ns/1ps
module bmo_ext_mem (
	input  wire logic [13:0] ext_addr_i,
	input  wire logic        sel_n_i,
	input  wire logic        rd_n_i,
	output logic      [23:0] ext_data_o
);
	initial ext_data_o = 24'h000000;
	// read data is the address pattern; a released bus shows the inverse
	always @(ext_addr_i or sel_n_i or rd_n_i) begin
		if (!sel_n_i && !rd_n_i)
			ext_data_o = {10'h000, ext_addr_i} ^ 24'h5A5A5A;
		else
			ext_data_o = ~ext_data_o;
	end
endmodule // bmo_ext_mem

//--- test/bmo_ctrl_test.sv
`timescale 1ns/1ps
module bmo_ctrl_test
	import bmo_pkg::*;
;
	logic core_clk_i = 1'b0, sys_rst_i = 1'b1, cyc = 1'b0, we = 1'b0, busy = 1'b0;
	logic mode_a = 1'b0, mode_b = 1'b0, mode_d = 1'b0, flag = 1'b0, word = 1'b0, pm0 = 1'b0;
	logic acc_valid = 1'b0, acc_done, acc_err, hold, full, bboot, ack_n, ack_oe, ack;
	logic pm_n, dm_n, io_n, rd_n, e, wb_ack, wr_n, oe, acc_we = 1'b0;
	logic [31:0] adr = 32'h0, dat = 32'h0, wb_q, q;
	logic [23:0] ext_d, q24, wd;
	logic [13:0] ext_a;
	bmo_acc_req_t req = '0;
	int n_errors = 0, n_tests = 0, ns, nw, o, m, n, r, d;

	always #2.5 core_clk_i = ~core_clk_i;
	// external pull-down on the open drain acknowledge
	assign ack = ack_oe ? ack_n : 1'b0;

	bmo_ctrl u_bmo_ctrl (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_dat_o(wb_q), .wb_ack_o(wb_ack), .mode_a_i(mode_a), .mode_b_i(mode_b),
		.mode_d_i(mode_d), .shared_flag_pin_two_i(flag), .byte_memory_dma_word_i(word),
		.host_internal_dma_pm0_wr_i(pm0), .host_busy_i(busy), .host_access_ack_n_o(ack_n),
		.host_access_ack_n_oe_o(ack_oe), .full_mem_mode_o(full), .byte_boot_req_o(bboot),
		.hold_exec_o(hold), .acc_valid_i(acc_valid), .acc_req_i(req), .ext_data_i(ext_d),
		.acc_done_o(acc_done), .acc_err_o(acc_err), .acc_rdata_o(q24), .ext_addr_o(ext_a),
		.ext_data_o(wd), .ext_data_oe_o(oe), .pm_sel_n_o(pm_n), .dm_sel_n_o(dm_n),
		.io_sel_n_o(io_n), .rd_n_o(rd_n), .wr_n_o(wr_n));
	bmo_ext_mem u_bmo_ext_mem (.ext_addr_i(ext_a), .sel_n_i(pm_n & dm_n & io_n),
		.rd_n_i(rd_n), .ext_data_o(ext_d));

	task finish_test;
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task timeout;
		n_errors++;
		finish_test();
	endtask
	task reset_dut(input logic c, b, a, dd);
		sys_rst_i <= 1'b1; flag <= c; mode_b <= b; mode_a <= a; mode_d <= dd;
		repeat (6) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
	endtask
	task wb(input logic [31:0] a, input logic w, input logic [31:0] wd);
		int i;
		cyc <= 1'b1; adr <= a; we <= w; dat <= wd;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk_i);
			if (wb_ack === 1'b1) break;
		end
		q = wb_q;
		cyc <= 1'b0; we <= 1'b0;
		if (i == 20) timeout();
		@(posedge core_clk_i);
	endtask
	task acc(input bmo_space_t sp, input logic [13:0] a);
		int i;
		ns = 0;
		nw = 0;
		req <= '{sp, 1'b0, acc_we, a, acc_we ? 24'hC3C3C3 : 24'h000000};
		acc_valid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk_i);
			if (acc_done === 1'b1) break;
			if (!(pm_n & dm_n & io_n)) ns++;
			if (wr_n === 1'b0 && oe === 1'b1 && wd === 24'hC3C3C3) nw++;
		end
		e = acc_err;
		acc_valid <= 1'b0;
		if (i == 40) timeout();
		@(posedge core_clk_i);
	endtask
	// drives the module signals directly: a task argument would only be a copy
	task pulse(input logic sel_pm0, input int k);
		repeat (k) begin
			if (sel_pm0)
				pm0 <= 1'b1;
			else
				word <= 1'b1;
			@(posedge core_clk_i);
			pm0 <= 1'b0;
			word <= 1'b0;
			@(posedge core_clk_i);
		end
	endtask

	initial begin
		reset_dut(1'b0, 1'b0, 1'b0, 1'b0);
		chk("full_mode", 1, full);
		chk("byte_boot", 1, bboot);
		// strap driver released: the pin now carries a flag
		flag <= 1'b1;
		pulse(1'b0, 31);
		chk("hold_31", 1, hold);
		pulse(1'b0, 1);
		repeat (3) @(posedge core_clk_i);
		chk("hold_32", 0, hold);
		chk("full_kept", 1, full);
		chk("ack_oe_full", 0, ack_oe);
		$display("test byte_boot done");
		for (o = 1; o < 3; o++) for (m = 0; m < 2; m++) for (n = 0; n < 8; n += 7) begin
			// reserved bits written as zero
			wb({28'h0, REG_WAIT_CTRL}, 1'b1, {16'h0, m[0], n[2:0], 12'h000});
			wb({28'h0, REG_OVERLAY}, 1'b1, {24'h0, o[3:0], 4'h0});
			acc(BMO_SPACE_DM, 14'h2005);
			chk("dm_strobes", m ? 2 * n + 2 : n + 1, ns);
			chk("dm_data", {10'h0, o == 2, 13'h0005} ^ 24'h5A5A5A, q24);
		end
		wb({28'h0, REG_WAIT_CTRL}, 1'b0, 32'h0);
		chk("wait_ctrl", 32'h0000F000, q);
		wb(32'h00000010, 1'b0, 32'h0);
		chk("unmapped", 0, q);
		wb({28'h0, REG_OVERLAY}, 1'b1, 32'h00000030);
		acc(BMO_SPACE_DM, 14'h2005);
		chk("ovl_bad", 1, e);
		acc(BMO_SPACE_DM, 14'h0100);
		chk("internal", 0, ns);
		wb({28'h0, REG_WAIT_CTRL}, 1'b1, 32'h000008D1);
		for (r = 0; r < 4; r++) begin
			acc(BMO_SPACE_IO, 14'(r * 32'h200 + 32'h5));
			chk("io_strobes", r + 2, ns);
			chk("io_data", 32'h25A ^ (r * 32'h200 + 32'h5), {21'h0, q24[10:0]});
		end
		acc_we = 1'b1;
		acc(BMO_SPACE_IO, 14'h0205);
		chk("io_wr_strobes", 3, ns);
		chk("io_wr_data", 3, nw);
		acc_we = 1'b0;
		wb({28'h0, REG_PROG_WAIT}, 1'b1, 32'h00000003);
		wb({28'h0, REG_OVERLAY}, 1'b1, 32'h00000001);
		acc(BMO_SPACE_PM, 14'h3000);
		chk("pm_strobes", 4, ns);
		chk("pm_data", {10'h0, 1'b0, 13'h1000} ^ 24'h5A5A5A, q24);
		wb({28'h0, REG_STATUS}, 1'b0, 32'h0);
		chk("status", 32'h00000050, q);
		$display("test wait_states done");
		for (d = 0; d < 2; d++) begin
			reset_dut(1'b1, 1'b0, d[0], d[0]);
			chk("host_full", 0, full);
			chk("host_bboot", d ? 0 : 1, bboot);
			busy <= 1'b1;
			repeat (3) @(posedge core_clk_i);
			chk("ack_busy", 1, ack);
			busy <= 1'b0;
			repeat (3) @(posedge core_clk_i);
			chk("ack_ready", 0, ack);
			chk("ack_oe", d ? 0 : 1, ack_oe);
			acc(BMO_SPACE_IO, 14'h0005);
			chk("host_io", 1, e);
			chk("host_hold", 1, hold);
			pulse(d[0], d ? 1 : 32);
			repeat (3) @(posedge core_clk_i);
			chk("host_release", 0, hold);
		end
		$display("test host_mode done");
		reset_dut(1'b0, 1'b1, 1'b0, 1'b0);
		chk("noboot_full", 1, full);
		chk("noboot_hold", 0, hold);
		chk("noboot_bboot", 0, bboot);
		$display("test no_boot done");
		finish_test();
	end
endmodule // bmo_ctrl_test

bind bmo_ctrl bmo_ctrl_properties u_bmo_ctrl_properties (.core_clk_i(core_clk_i),
	.sys_rst_i(sys_rst_i), .mode_d_i(mode_d_i), .byte_memory_dma_word_i(byte_memory_dma_word_i),
	.host_internal_dma_pm0_wr_i(host_internal_dma_pm0_wr_i),
	.host_access_ack_n_o(host_access_ack_n_o), .host_access_ack_n_oe_o(host_access_ack_n_oe_o),
	.full_mem_mode_o(full_mem_mode_o), .hold_exec_o(hold_exec_o), .acc_done_o(acc_done_o),
	.acc_err_o(acc_err_o), .ext_addr_o(ext_addr_o), .pm_sel_n_o(pm_sel_n_o),
	.dm_sel_n_o(dm_sel_n_o), .io_sel_n_o(io_sel_n_o));
